// file: hw/qbp_pkg.sv
// Purpose: shared constants and carriers for the port pin block
// Assumes: 100 MHz core clock
// Notes:   transition driver length is a cycle count
package qbp_pkg;

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam int unsigned PORT_W        = 8;
    localparam logic [7:0]  PORT_RST      = 8'hff;
    localparam int unsigned REF_CLK_NS    = 10;
    localparam int unsigned KICK_NS       = 20;
    localparam int unsigned KICK_CYC      = (KICK_NS + REF_CLK_NS - 1) / REF_CLK_NS;
    localparam int unsigned SYNC_STAGES   = 2;

    // port 1 alternate bit positions
    localparam int unsigned P1_T2         = 0;
    localparam int unsigned P1_TIMER_TWO_CAPTURE_TRIGGER       = 1;
    localparam int unsigned P1_SIN        = 2;
    localparam int unsigned P1_SOUT       = 3;
    localparam int unsigned P1_IRQ2       = 4;
    localparam int unsigned P1_IRQ3       = 5;
    localparam int unsigned P1_IRQ4       = 6;
    localparam int unsigned P1_IRQ5       = 7;
    // port 3 alternate bit positions
    localparam int unsigned P3_SIN0       = 0;
    localparam int unsigned P3_SOUT0      = 1;
    localparam int unsigned P3_IRQ0       = 2;
    localparam int unsigned P3_IRQ1       = 3;
    localparam int unsigned P3_T0         = 4;
    localparam int unsigned P3_T1         = 5;
    localparam int unsigned P3_WRS        = 6;
    localparam int unsigned P3_RDS        = 7;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       req;      // access in progress
        logic       ale;      // address latch strobe level
        logic       wr;       // data phase drives port 0
        logic       via_ri;   // 8-bit pointer move
        logic [15:0] addr;
        logic [7:0] wdata;
    } qbp_bus_t;

    typedef struct packed {
        logic [7:0] pull_dn;  // strong pulldown enables
        logic [7:0] kick_hi;  // strong high driver enables
    } qbp_drv_t;

endpackage : qbp_pkg

// file: hw/qbp_sync.sv
// Purpose: two-stage synchroniser for a vector of pin levels
// Assumes: pins asynchronous to REF_CLK
// Notes:   first stage read only by the second
`timescale 1ns/10ps
`default_nettype none
module qbp_sync #(
    parameter int unsigned W = 8
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic [W-1:0]  d,
    output logic      [W-1:0]  q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s1_d;
    logic [W-1:0] s2_d;

    always_comb begin
        s1_d = d;
        s2_d = s1_q;
    end

    // reset to one matches the weak-pullup idle level
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            s1_q <= '1;
            s2_q <= '1;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
        end
    end

    assign q = s2_q;
endmodule : qbp_sync
`default_nettype wire

// file: hw/qbp_qport.sv
// Purpose: one quasi-bidirectional 8-bit port driver
// Assumes: latch written by core, one write per cycle at most
// Notes:   transition driver length set by KICK parameter
`timescale 1ns/10ps
`default_nettype none
module qbp_qport
    import qbp_pkg::*;
#(
    parameter int unsigned KICK = KICK_CYC
) (
    input  wire logic          clk,
    input  wire logic          rst_b,
    input  wire logic [7:0]    latch,
    output qbp_pkg::qbp_drv_t  drv
);
    import qbp_pkg::*;

    logic [7:0] prev_q;
    logic [7:0] prev_d;
    logic [7:0] pd_q;
    logic [7:0] pd_d;
    logic [7:0] kh_q;
    logic [7:0] kh_d;
    logic [3:0] cnt_q [8];
    logic [3:0] cnt_d [8];

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_bit
            always_comb begin
                cnt_d[g] = cnt_q[g];
                kh_d[g]  = kh_q[g];
                pd_d[g]  = ~latch[g];
                if (latch[g] && !prev_q[g]) begin
                    kh_d[g]  = 1'b1;
                    cnt_d[g] = 4'(KICK - 1);
                end else if (kh_q[g]) begin
                    if (cnt_q[g] == 4'h0) begin
                        kh_d[g] = 1'b0;
                    end else begin
                        cnt_d[g] = cnt_q[g] - 4'h1;
                    end
                end
                if (!latch[g]) begin
                    kh_d[g] = 1'b0;
                end
            end

            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    cnt_q[g] <= 4'h0;
                end else begin
                    cnt_q[g] <= cnt_d[g];
                end
            end
        end
    endgenerate

    always_comb begin
        prev_d = latch;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            prev_q <= PORT_RST;
            pd_q   <= 8'h00;
            kh_q   <= 8'h00;
        end else begin
            prev_q <= prev_d;
            pd_q   <= pd_d;
            kh_q   <= kh_d;
        end
    end

    assign drv.pull_dn = pd_q;
    assign drv.kick_hi = kh_q;

    AST_KICK_ON: assert property (@(posedge clk) disable iff (!rst_b)
        (latch[0] && !prev_q[0]) |=> kh_q[0] && !pd_q[0])
        else $error("kick driver missing after one write");
    AST_KICK_OFF: assert property (@(posedge clk) disable iff (!rst_b)
        (latch[0] && !prev_q[0]) ##1 latch[0] [*4] |=> !kh_q[0])
        else $error("kick driver stayed on");
endmodule : qbp_qport
`default_nettype wire

// file: hw/qbp_ports.sv
// Purpose: port 0/1/2/3 pin logic of the bus-capable controller
// Assumes: core presents bus phases; pins resolved outside
// Notes:   weak pullup is implied when no strong enable is on
`timescale 1ns/10ps
`default_nettype none

// Function
// - muxed mode: address while strobe high, then data
// - demuxed mode: port 0 carries data only
// - port 0 high after reset, bus-owned
// - split select high: port 1 gives address
// - relocate bit moves serial one to port 5
// - ports 1,3 reset high by weak pullup
// - a one-written pin reads external level
// - written zero enables strong pulldown until one
// - zero-to-one gives brief strong high drive
// - port 2 carries high address each access
// - port 2 register reaches pins only on pointer moves
// - pointer moves use port 2 register high byte
// - port 1 bits 0-3 timer two and serial
// - port 1 bits 4-7 edge interrupts two-five
// - port 3 bits 0-4 serial, irq, timer
// - port 3 bit 5 timer/clock, bit 6 write
// - port 3 bit 7 read strobe
module qbp_ports
    import qbp_pkg::*;
#(
    parameter int unsigned KICK = KICK_CYC
) (
    input  wire logic          REF_CLK,
    input  wire logic          RST_B,
    input  wire logic          BUS_SPLIT_SELECT,
    input  wire logic          SERIAL_ONE_RELOCATE,
    input  wire qbp_pkg::qbp_bus_t BUS,
    input  wire logic [7:0]    P1_LATCH,
    input  wire logic [7:0]    P2_LATCH,
    input  wire logic [7:0]    P3_LATCH,
    input  wire logic          SERIAL_ZERO_OUT,
    input  wire logic          SERIAL_ONE_OUT,
    input  wire logic          TIMER_ONE_CLOCK_OUT,
    input  wire logic          CLOCK_OUT_EN,
    input  wire logic          WR_STROBE_B,
    input  wire logic          RD_STROBE_B,
    input  wire logic [7:0]    SHARED_ADDR_DATA_BUS_IN,
    input  wire logic [7:0]    P1_IN,
    input  wire logic [7:0]    P3_IN,
    output logic      [7:0]    SHARED_ADDR_DATA_BUS_OUT,
    output logic      [7:0]    SHARED_ADDR_DATA_BUS_OE,
    output logic      [7:0]    P0_READ,
    output logic      [7:0]    P2_OUT,
    output logic      [7:0]    P1_PULL_DN,
    output logic      [7:0]    P1_KICK_HI,
    output logic      [7:0]    P1_READ,
    output logic      [7:0]    P3_PULL_DN,
    output logic      [7:0]    P3_KICK_HI,
    output logic      [7:0]    P3_READ,
    output logic               P5_SERIAL_ONE_OUT,
    output logic               SERIAL_ONE_ROUTED_OUT,
    output logic               TIMER_TWO_PIN,
    output logic               TIMER_TWO_CAPTURE_TRIGGER,
    output logic               EXT_IRQ_TWO_RISE,
    output logic               EXT_IRQ_THREE_FALL,
    output logic               EXT_IRQ_FOUR_RISE,
    output logic               EXT_IRQ_FIVE_FALL,
    output logic               EXT_IRQ_ZERO,
    output logic               EXT_IRQ_ONE,
    output logic               TIMER_ZERO_INPUT,
    output logic               TIMER_ONE_INPUT
);
    import qbp_pkg::*;

    // ------------------------------------------------------------
    // synchronised pin levels
    // ------------------------------------------------------------
    logic [7:0] p0_s;
    logic [7:0] p1_s;
    logic [7:0] p3_s;

    qbp_sync #(.W(PORT_W)) u_s0 (.clk(REF_CLK), .rst_b(RST_B),
        .d(SHARED_ADDR_DATA_BUS_IN), .q(p0_s));
    qbp_sync #(.W(PORT_W)) u_s1 (.clk(REF_CLK), .rst_b(RST_B),
        .d(P1_IN), .q(p1_s));
    qbp_sync #(.W(PORT_W)) u_s3 (.clk(REF_CLK), .rst_b(RST_B),
        .d(P3_IN), .q(p3_s));

    // ------------------------------------------------------------
    // effective latches with alternate outputs folded in
    // ------------------------------------------------------------
    // an alternate output only pulls low; a zero latch still wins, except when the split-mode bus address replaces port 1
    logic [7:0] p1_eff;
    logic [7:0] p3_eff;
    logic       s1_on_p1;

    function automatic logic [7:0] fold(input logic [7:0] l, input int unsigned b, input logic v);
        logic [7:0] r;
        r    = l;
        r[b] = l[b] & v;
        return r;
    endfunction : fold

    always_comb begin
        s1_on_p1 = ~SERIAL_ONE_RELOCATE;
        p1_eff   = fold(P1_LATCH, P1_SOUT, s1_on_p1 ? SERIAL_ONE_OUT : 1'b1);
        if (BUS_SPLIT_SELECT && BUS.req) begin
            p1_eff = BUS.addr[7:0];
        end
        p3_eff = fold(P3_LATCH, P3_SOUT0, SERIAL_ZERO_OUT);
        p3_eff = fold(p3_eff, P3_T1, CLOCK_OUT_EN ? TIMER_ONE_CLOCK_OUT : 1'b1);
        p3_eff = fold(p3_eff, P3_WRS, WR_STROBE_B);
        p3_eff = fold(p3_eff, P3_RDS, RD_STROBE_B);
    end

    qbp_drv_t d1;
    qbp_drv_t d3;

    qbp_qport #(.KICK(KICK)) u_q1 (.clk(REF_CLK), .rst_b(RST_B), .latch(p1_eff), .drv(d1));
    qbp_qport #(.KICK(KICK)) u_q3 (.clk(REF_CLK), .rst_b(RST_B), .latch(p3_eff), .drv(d3));

    // ------------------------------------------------------------
    // port 0 / port 2 bus drive
    // ------------------------------------------------------------
    logic [7:0] p0o_d;
    logic [7:0] p0o_q;
    logic [7:0] p0e_d;
    logic [7:0] p0e_q;
    logic [7:0] p2_d;
    logic [7:0] p2_q;

    always_comb begin
        // idle drives high: no external pullups required
        p0o_d = 8'hff;
        p0e_d = 8'hff;
        p2_d  = p2_q;
        if (BUS.req) begin
            // pointer moves take the high byte from the port 2 latch
            p2_d = BUS.via_ri ? P2_LATCH : BUS.addr[15:8];
            if (!BUS_SPLIT_SELECT && BUS.ale) begin
                p0o_d = BUS.addr[7:0];
                p0e_d = 8'hff;
            end else if (BUS.wr) begin
                p0o_d = BUS.wdata;
                p0e_d = 8'hff;
            end else begin
                p0o_d = 8'hff;
                p0e_d = 8'h00;
            end
        end
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    logic [7:0] rd0_d;
    logic [7:0] rd1_d;
    logic [7:0] rd3_d;
    logic [7:0] rd0_q;
    logic [7:0] rd1_q;
    logic [7:0] rd3_q;
    logic [7:0] p1d_q;
    logic [7:0] p1k_q;
    logic [7:0] p3d_q;
    logic [7:0] p3k_q;
    logic [1:0] ser_d;
    logic [1:0] ser_q;

    always_comb begin
        rd0_d = p0_s;
        rd1_d = p1_s;
        rd3_d = p3_s;
        ser_d[0] = SERIAL_ONE_RELOCATE ? SERIAL_ONE_OUT : 1'b1;
        ser_d[1] = SERIAL_ONE_OUT;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            p0o_q <= 8'hff;
            p0e_q <= 8'hff;
            p2_q  <= 8'hff;
            rd0_q <= 8'hff;
            rd1_q <= PORT_RST;
            rd3_q <= PORT_RST;
            p1d_q <= 8'h00;
            p1k_q <= 8'h00;
            p3d_q <= 8'h00;
            p3k_q <= 8'h00;
            ser_q <= 2'h3;
        end else begin
            p0o_q <= p0o_d;
            p0e_q <= p0e_d;
            p2_q  <= p2_d;
            rd0_q <= rd0_d;
            rd1_q <= rd1_d;
            rd3_q <= rd3_d;
            p1d_q <= d1.pull_dn;
            p1k_q <= d1.kick_hi;
            p3d_q <= d3.pull_dn;
            p3k_q <= d3.kick_hi;
            ser_q <= ser_d;
        end
    end

    assign SHARED_ADDR_DATA_BUS_OUT = p0o_q;
    assign SHARED_ADDR_DATA_BUS_OE  = p0e_q;
    assign P0_READ     = rd0_q;
    assign P2_OUT      = p2_q;
    assign P1_PULL_DN  = p1d_q;
    assign P1_KICK_HI  = p1k_q;
    assign P3_PULL_DN  = p3d_q;
    assign P3_KICK_HI  = p3k_q;
    assign P1_READ     = rd1_q;
    assign P3_READ     = rd3_q;
    assign P5_SERIAL_ONE_OUT      = ser_q[0];
    assign SERIAL_ONE_ROUTED_OUT  = ser_q[1];

    // alternate inputs straight from registered read levels
    assign TIMER_TWO_PIN             = rd1_q[P1_T2];
    assign TIMER_TWO_CAPTURE_TRIGGER = rd1_q[P1_TIMER_TWO_CAPTURE_TRIGGER];
    assign EXT_IRQ_TWO_RISE          = rd1_q[P1_IRQ2];
    assign EXT_IRQ_THREE_FALL        = rd1_q[P1_IRQ3];
    assign EXT_IRQ_FOUR_RISE         = rd1_q[P1_IRQ4];
    assign EXT_IRQ_FIVE_FALL         = rd1_q[P1_IRQ5];
    assign EXT_IRQ_ZERO              = rd3_q[P3_IRQ0];
    assign EXT_IRQ_ONE               = rd3_q[P3_IRQ1];
    assign TIMER_ZERO_INPUT          = rd3_q[P3_T0];
    assign TIMER_ONE_INPUT           = rd3_q[P3_T1];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_addr_phase;
        BUS.req && !BUS_SPLIT_SELECT && BUS.ale;
    endsequence

    AST_MUX_ADDR: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        s_addr_phase |=> (P2_OUT == $past(BUS.via_ri ? P2_LATCH : BUS.addr[15:8]))
                         && (SHARED_ADDR_DATA_BUS_OE == 8'hff))
        else $error("address phase not driven");
    AST_DEMUX_NOADDR: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (BUS.req && BUS_SPLIT_SELECT && !BUS.wr) |=> SHARED_ADDR_DATA_BUS_OE == 8'h00)
        else $error("demux read still drives port 0");
    AST_P0_IDLE: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !BUS.req |=> SHARED_ADDR_DATA_BUS_OUT == 8'hff && SHARED_ADDR_DATA_BUS_OE == 8'hff)
        else $error("port 0 idle not high");
    AST_P1_ADDR: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (BUS.req && BUS_SPLIT_SELECT && !BUS.addr[0]) |=> ##1 P1_PULL_DN[0])
        else $error("port 1 address bit not driven");
    AST_RELOC: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (SERIAL_ONE_RELOCATE && !SERIAL_ONE_OUT) |=> !P5_SERIAL_ONE_OUT)
        else $error("relocated serial output missing");
    AST_PULLDN: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        (!P3_LATCH[4]) |=> ##1 (P3_PULL_DN[4] && !P3_KICK_HI[4]))
        else $error("pulldown not enabled");
    // the release edge still finds the stages in reset, so skip pins seen before it
    AST_READ_SYNC: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        $past(RST_B, 3) |-> P1_READ == $past(P1_IN, 3))
        else $error("port 1 read not three cycles late");
    AST_P2_HOLD: assert property (@(posedge REF_CLK) disable iff (!RST_B)
        !BUS.req |=> $stable(P2_OUT))
        else $error("port 2 changed outside access");
endmodule : qbp_ports
`default_nettype wire

// file: tb/qbp_board.sv
// Purpose: board, latch and memory model on the port pins
// Assumes: pins resolved every cycle from all drivers
// Notes:   a released port 0 shows memory data, or the inverted last level when memory does not drive
`timescale 1ns/10ps
`default_nettype none
module qbp_board (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  p0_out,
    input  wire logic [7:0]  p0_oe,
    input  wire logic [7:0]  p1_pd,
    input  wire logic [7:0]  p1_kh,
    input  wire logic [7:0]  p3_pd,
    input  wire logic [7:0]  p3_kh,
    input  wire logic [15:0] ext_en,
    input  wire logic [15:0] ext_val,
    input  wire logic        mem_drv,
    input  wire logic [7:0]  mem_data,
    output logic      [7:0]  p0_pin,
    output logic      [7:0]  p1_pin,
    output logic      [7:0]  p3_pin
);
    logic [7:0] last_q;

    // ------------------------------------------------------------
    // pin resolution
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) last_q <= 8'hff;
        else last_q <= p0_pin;
    end

    always_comb begin
        for (int b = 0; b < 8; b++) begin
            // no stale value once nobody drives the bus
            p0_pin[b] = p0_oe[b] ? p0_out[b] : (mem_drv ? mem_data[b] : ~last_q[b]);
            p1_pin[b] = p1_pd[b] ? 1'b0 : p1_kh[b] ? 1'b1 : ext_en[b] ? ext_val[b] : 1'b1;
            p3_pin[b] = p3_pd[b] ? 1'b0 : p3_kh[b] ? 1'b1 : ext_en[b+8] ? ext_val[b+8] : 1'b1;
        end
    end
endmodule : qbp_board
`default_nettype wire

// file: tb/tb_quasi_bidir_ports_bus_pins.sv
// Purpose: random self-checking bench for the port pin block
// Assumes: split select static between resets
// Notes:   reference model tracks pipelines per cycle
`timescale 1ns/10ps
`default_nettype none
module tb_quasi_bidir_ports_bus_pins;
    import qbp_pkg::*;
    localparam int unsigned KICK_T = 3;
    logic        ref_clk, rst_b, split, reloc, so0, so1, t1clk, clk_en, wr_b, rd_b, mem_drv, drive_en;
    qbp_bus_t    bus, bprev;
    logic [7:0]  p1_lat, p2_lat, p3_lat, mem_data, p0_in, p1_in, p3_in, p0_out, p0_oe, p0_rd, p2_out;
    logic [7:0]  p1_pd, p1_kh, p1_rd, p3_pd, p3_kh, p3_rd, e1, e3, k1, k3, p2_exp, p2prev;
    logic [15:0] ext_en, ext_val;
    logic        p5_so, so1r, t2, timer_two_capture_trigger, i2, i3, i4, i5, i0, i1, t0, t1, rel_prev, so1_prev;
    logic [7:0]  e1_h[4], e3_h[4], pin0_h[4], pin1_h[4], pin3_h[4];
    logic [31:0] seed, r, s, t;
    int          err_count, samples_checked, age, kc1[8], kc3[8];

    qbp_ports #(.KICK(KICK_T)) dut_u (
        .REF_CLK(ref_clk), .RST_B(rst_b), .BUS_SPLIT_SELECT(split), .SERIAL_ONE_RELOCATE(reloc),
        .BUS(bus), .P1_LATCH(p1_lat), .P2_LATCH(p2_lat), .P3_LATCH(p3_lat),
        .SERIAL_ZERO_OUT(so0), .SERIAL_ONE_OUT(so1), .TIMER_ONE_CLOCK_OUT(t1clk), .CLOCK_OUT_EN(clk_en),
        .WR_STROBE_B(wr_b), .RD_STROBE_B(rd_b), .SHARED_ADDR_DATA_BUS_IN(p0_in), .P1_IN(p1_in), .P3_IN(p3_in),
        .SHARED_ADDR_DATA_BUS_OUT(p0_out), .SHARED_ADDR_DATA_BUS_OE(p0_oe), .P0_READ(p0_rd), .P2_OUT(p2_out),
        .P1_PULL_DN(p1_pd), .P1_KICK_HI(p1_kh), .P1_READ(p1_rd), .P3_PULL_DN(p3_pd), .P3_KICK_HI(p3_kh),
        .P3_READ(p3_rd), .P5_SERIAL_ONE_OUT(p5_so), .SERIAL_ONE_ROUTED_OUT(so1r), .TIMER_TWO_PIN(t2),
        .TIMER_TWO_CAPTURE_TRIGGER(timer_two_capture_trigger), .EXT_IRQ_TWO_RISE(i2), .EXT_IRQ_THREE_FALL(i3),
        .EXT_IRQ_FOUR_RISE(i4), .EXT_IRQ_FIVE_FALL(i5), .EXT_IRQ_ZERO(i0), .EXT_IRQ_ONE(i1),
        .TIMER_ZERO_INPUT(t0), .TIMER_ONE_INPUT(t1));

    qbp_board board_u (.clk(ref_clk), .rst_b(rst_b), .p0_out(p0_out), .p0_oe(p0_oe), .p1_pd(p1_pd),
        .p1_kh(p1_kh), .p3_pd(p3_pd), .p3_kh(p3_kh), .ext_en(ext_en), .ext_val(ext_val),
        .mem_drv(mem_drv), .mem_data(mem_data), .p0_pin(p0_in), .p1_pin(p1_in), .p3_pin(p3_in));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : end_sim

    // ------------------------------------------------------------
    // clock, stimulus, watchdog
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        if (drive_en) begin
            r = rnd();
            s = rnd();
            t = rnd();
            bus <= '{r[0] | r[1], r[2], r[3], r[4], s[15:0], s[23:16]};
            if (r[7:5] == 3'h0) p1_lat <= s[31:24];
            if (r[10:8] == 3'h0) p3_lat <= r[31:24];
            if (r[15:11] == 5'h00) reloc <= ~reloc;
            if (r[20:16] == 5'h00) clk_en <= ~clk_en;
            p2_lat <= t[7:0];
            so0 <= r[21] | r[22];
            so1 <= r[23] | r[24];
            t1clk <= r[25];
            wr_b <= |r[28:26];
            rd_b <= |t[10:8];
            mem_drv <= r[29];
            mem_data <= t[31:24];
            ext_en <= {s[7:0], t[15:8]};
            ext_val <= t[31:16];
        end
    end

    initial begin
        #400000;
        err_count++;
        end_sim();
    end

    // ------------------------------------------------------------
    // reference model, compared every cycle
    // ------------------------------------------------------------
    always @(negedge ref_clk) begin
        if (!rst_b) begin
            age = 0;
            p2_exp = 8'hff;
            bprev = '0;
            for (int i = 0; i < 4; i++) begin
                e1_h[i] = 8'hff;
                e3_h[i] = 8'hff;
            end
            for (int b = 0; b < 8; b++) begin
                kc1[b] = 0;
                kc3[b] = 0;
            end
        end else begin
            age++;
            e1 = p1_lat;
            if (!reloc) e1[P1_SOUT] = e1[P1_SOUT] & so1;
            if (split && bus.req) e1 = bus.addr[7:0];
            e3 = p3_lat;
            e3[P3_SOUT0] = e3[P3_SOUT0] & so0;
            e3[P3_T1] = e3[P3_T1] & (clk_en ? t1clk : 1'b1);
            e3[P3_WRS] = e3[P3_WRS] & wr_b;
            e3[P3_RDS] = e3[P3_RDS] & rd_b;
            for (int i = 3; i > 0; i--) begin
                e1_h[i] = e1_h[i-1];
                e3_h[i] = e3_h[i-1];
                pin0_h[i] = pin0_h[i-1];
                pin1_h[i] = pin1_h[i-1];
                pin3_h[i] = pin3_h[i-1];
            end
            e1_h[0] = e1;
            e3_h[0] = e3;
            pin0_h[0] = p0_in;
            pin1_h[0] = p1_in;
            pin3_h[0] = p3_in;
            for (int b = 0; b < 8; b++) begin
                if (e1_h[2][b] && !e1_h[3][b]) kc1[b] = KICK_T;
                else if (!e1_h[2][b]) kc1[b] = 0;
                if (e3_h[2][b] && !e3_h[3][b]) kc3[b] = KICK_T;
                else if (!e3_h[2][b]) kc3[b] = 0;
                k1[b] = kc1[b] > 0;
                k3[b] = kc3[b] > 0;
                if (kc1[b] > 0) kc1[b]--;
                if (kc3[b] > 0) kc3[b]--;
            end
            if (bprev.req) p2_exp = bprev.via_ri ? p2prev : bprev.addr[15:8];
            if (age >= 4) begin
                chk(p2_out, p2_exp, "high address");
                chk({p5_so, so1r}, {rel_prev ? so1_prev : 1'b1, so1_prev}, "serial one out");
                chk({p1_pd, p3_pd}, 16'(~{e1_h[2], e3_h[2]}), "pulldown");
                chk({p1_kh & e1_h[2], p3_kh & e3_h[2]}, {k1 & e1_h[2], k3 & e3_h[2]}, "kick");
                chk({p0_rd, p1_rd, p3_rd}, {pin0_h[3], pin1_h[3], pin3_h[3]}, "read");
                chk({i5, i4, i3, i2, timer_two_capture_trigger, t2}, {pin1_h[3][7:4], pin1_h[3][1:0]}, "port 1 alt in");
                chk({t1, t0, i1, i0}, pin3_h[3][5:2], "port 3 alt in");
                if (bprev.req && !split && bprev.ale) begin
                    chk({p0_oe, p0_out}, {8'hff, bprev.addr[7:0]}, "address phase");
                end else if (bprev.req) begin
                    chk(p0_oe, bprev.wr ? 8'hff : 8'h00, "data direction");
                    if (bprev.wr) chk(p0_out, bprev.wdata, "write data");
                end
            end
            bprev = bus;
            p2prev = p2_lat;
            rel_prev = reloc;
            so1_prev = so1;
        end
    end

    // ------------------------------------------------------------
    // phases: multiplexed, then demultiplexed after a fresh reset
    // ------------------------------------------------------------
    task automatic run_phase(input logic mode);
        // stop the stimulus one edge early so no input gets two drivers in one step
        @(posedge ref_clk);
        drive_en <= 1'b0;
        @(posedge ref_clk);
        rst_b <= 1'b0;
        split <= mode;
        bus <= '0;
        {p1_lat, p3_lat, so0, so1, wr_b, rd_b} <= '1;
        repeat (2) @(posedge ref_clk);
        @(negedge ref_clk);
        chk({p0_oe, p0_out, p2_out}, 24'hffffff, "port 0/2 reset");
        chk({p1_pd, p3_pd, p1_kh, p3_kh}, 32'h0, "port 1/3 reset drive");
        chk({p1_rd, p3_rd, p0_rd, 7'h00, p5_so}, 32'hffffff01, "reset reads");
        @(posedge ref_clk);
        rst_b <= 1'b1;
        drive_en <= 1'b1;
        repeat (1500) @(posedge ref_clk);
    endtask : run_phase

    initial begin
        seed = 32'd91;
        {rst_b, drive_en, split, reloc, t1clk, clk_en, mem_drv} = '0;
        {so0, so1, wr_b, rd_b} = '1;
        bus = '0;
        {p1_lat, p2_lat, p3_lat, mem_data} = {8'hff, 8'h00, 8'hff, 8'h00};
        {ext_en, ext_val} = '0;
        err_count = 0;
        samples_checked = 0;
        run_phase(1'b0);
        run_phase(1'b1);
        end_sim();
    end
endmodule : tb_quasi_bidir_ports_bus_pins
`default_nettype wire
